// >>> common/reset_seq_defs.svh
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_STATUS        12'h003
`define IDX_PC_LOW        12'h002
`define IDX_IRQ_CONTROL   12'h00b
`define IDX_OPTION        12'h081
`define IDX_DIR_A         12'h085
`define IDX_DIR_B         12'h086
`define IDX_POWER_CONTROL 12'h08e
`define IDX_CONFIG        12'h090
`define IDX_CAUSE         12'h091
`define IDX_TO_ADDR(i)    ((i) << 2)

// field positions
`define ST_TIMEOUT_BIT    4
`define ST_POWERDOWN_BIT  3
`define POWER_CONTROL_FLAGS_POR_BIT      1
`define IRQ_GLOBAL_BIT    7
`define CFG_DELAY_DIS_BIT 2

// reset values
`define OPTION_RESET      8'hff
`define DIR_A_RESET       5'h1f
`define DIR_B_RESET       8'hff
`define CONFIG_RESET      3'h1
`define RESET_VECTOR      13'h0000
`define IRQ_VECTOR        13'h0004

// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// timing
`define CLK_MHZ           125
`define MASTER_CLEAR_MIN_NS 2000
`define POWER_UP_DELAY_US 72000
`define SLOW_OSC_KHZ      32
`define OSC_STARTUP_COUNT 1024
`define CLOCK_OUT_DIVIDE  4

// async input lanes
`define LANE_SUPPLY       0
`define LANE_MASTER_CLEAR 1
`define LANE_CLOCK_IN     2
`define LANE_SLOW_OSC     3

`endif

// >>> common/reset_seq_pkg.sv
package reset_seq_pkg;

   typedef enum logic [4:0] {
      ST_POWER_UP   = 5'h01,
      ST_OSC_START  = 5'h02,
      ST_HOLD       = 5'h04,
      ST_RUN        = 5'h08,
      ST_SLEEP      = 5'h10
   } seq_state_t;

   typedef enum logic [2:0] {
      CAUSE_NONE         = 3'h0,
      CAUSE_POWER_ON     = 3'h1,
      CAUSE_CLEAR_RUN    = 3'h2,
      CAUSE_CLEAR_SLEEP  = 3'h3,
      CAUSE_WATCHDOG     = 3'h4,
      CAUSE_WATCHDOG_WAKE = 3'h5,
      CAUSE_IRQ_WAKE     = 3'h6
   } reset_cause_t;

   typedef enum logic [1:0] {
      OSC_LOW_POWER_CRYSTAL = 2'h0,
      OSC_CRYSTAL           = 2'h1,
      OSC_HIGH_SPEED        = 2'h2,
      OSC_RES_CAP           = 2'h3
   } osc_mode_t;

   typedef struct packed {
      logic [3:0]   sync1;
      logic [3:0]   sync2;
      logic [3:0]   sync3;
      logic [3:0]   clean;
      logic [7:0]   filt_cnt;
      logic         clear_n;
      seq_state_t   state;
      logic [15:0]  delay_cnt;
      logic [10:0]  start_cnt;
      logic         wake_start;
      logic         vec_pending;
      logic [12:0]  wake_pc;
      logic         div_phase;
      logic [7:0]   status;
      logic         power_control_flags_por;
      logic [7:0]   pc_low;
      logic [7:0]   option;
      logic [4:0]   dir_a;
      logic [7:0]   dir_b;
      logic [7:0]   irq_ctl;
      logic [7:0]   scratch;
      logic [2:0]   cfg;
      reset_cause_t cause;
      logic         core_reset;
      logic         core_stall;
      logic         osc_enable;
      logic         wd_clear;
      logic         pc_load;
      logic [12:0]  pc_value;
      logic         clock_out;
      logic         clock_out_oe;
      logic         aw_got;
      logic         w_got;
      logic [11:0]  aw_addr;
      logic [7:0]   w_data;
      logic         w_lane0;
      logic         awready;
      logic         wready;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         arready;
      logic         rvalid;
      logic [1:0]   rresp;
      logic [31:0]  rdata;
   } seq_regs_t;

endpackage : reset_seq_pkg

// >>> design/reset_timeout_sequencer.sv
// Contract
// R01 - in RC oscillator mode drive clock output at oscillator frequency over four
// R02 - tell apart power-on, clear in run, clear in sleep, watchdog reset, watchdog wake
// R03 - some registers have no reset value and keep contents on every reset
// R04 - most registers reset on power-on, clear and watchdog reset, not on wake
// R05 - master-clear input is filtered so short glitches cause no reset
// R06 - power-on pulse only on rising supply, never on falling supply
// R07 - power-up timer starts from power-on pulse only, nominal 72 ms on slow oscillator
// R08 - core stays in reset while the power-up timer runs
// R09 - config bit one skips the power-up timer, zero uses it
// R10 - after power-up delay count 1024 clock input cycles before release
// R11 - start-up count only in crystal modes, only after power-on or wake
// R12 - power-up order: power-on pulse, then power-up delay, then start-up count
// R13 - RC mode: no delay if disabled, else only the power-up delay
// R14 - timers run regardless of master-clear; release follows clear going high
// R15 - power-control bit 1 reads 0 after power-on, otherwise kept; software sets it
// R16 - timeout and power-down flags encode the reset cause per event
// R17 - reset loads pc 000h; wake continues pc+1; interrupt vector 0004h afterwards
// R18 - status register takes the listed value for each event
// R19 - pc low, option, port directions, interrupt control reset; wake keeps them, but wake loads pc low with pc+1
// R20 - wake from sleep sets at least one interrupt control flag of the source
// R21 - sleep clears power-down, sets timeout, clears watchdog, stops oscillator driver
// R22 - watchdog time-out clears the timeout flag
// R23 - two config bits select one of four oscillator modes
// R24 - reset release synchronised to clock; power-up delay parameter in slow ticks
// R25 - new power-on during start-up restarts the sequence, core held in reset
`timescale 1ns/100ps
`include "reset_seq_defs.svh"

module reset_timeout_sequencer #(
   parameter int SLOW_OSC_KHZ     = `SLOW_OSC_KHZ,
   parameter int POWER_UP_TICKS   = `POWER_UP_DELAY_US * SLOW_OSC_KHZ / 1000,
   parameter int OSC_START_CYCLES = `OSC_STARTUP_COUNT
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // axi4-lite slave
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // asynchronous pins
   input  wire logic        supply_rise,
   input  wire logic        master_clear_n,
   input  wire logic        clock_in_pin,
   input  wire logic        slow_osc_clk,
   // core side
   input  wire logic        watchdog_timeout,
   input  wire logic        sleep_exec,
   input  wire logic [2:0]  irq_wake_req,
   input  wire logic [12:0] current_pc,
   input  wire logic        instr_retired,
   // sequencer outputs
   output logic             core_reset,
   output logic             core_stall,
   output logic             osc_driver_enable,
   output logic             watchdog_clear,
   output logic             pc_load,
   output logic [12:0]      pc_value,
   output logic             clock_out_pin,
   output logic             clock_out_oe,
   output logic [2:0]       reset_cause
);

   localparam int CLEAR_FILT_CYCLES =
      (`MASTER_CLEAR_MIN_NS * `CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  FILT_LAST  = 8'(CLEAR_FILT_CYCLES - 1);
   localparam logic [15:0] DELAY_LAST = 16'(POWER_UP_TICKS - 1);
   localparam logic [10:0] START_LAST = 11'(OSC_START_CYCLES - 1);
   localparam logic [11:0] ADDR_STATUS = `IDX_TO_ADDR(`IDX_STATUS);
   localparam logic [11:0] ADDR_PC_LOW = `IDX_TO_ADDR(`IDX_PC_LOW);
   localparam logic [11:0] ADDR_IRQ    = `IDX_TO_ADDR(`IDX_IRQ_CONTROL);
   localparam logic [11:0] ADDR_OPTION = `IDX_TO_ADDR(`IDX_OPTION);
   localparam logic [11:0] ADDR_DIR_A  = `IDX_TO_ADDR(`IDX_DIR_A);
   localparam logic [11:0] ADDR_DIR_B  = `IDX_TO_ADDR(`IDX_DIR_B);
   localparam logic [11:0] ADDR_POWER_CONTROL_FLAGS   = `IDX_TO_ADDR(`IDX_POWER_CONTROL);
   localparam logic [11:0] ADDR_CONFIG = `IDX_TO_ADDR(`IDX_CONFIG);
   localparam logic [11:0] ADDR_CAUSE  = `IDX_TO_ADDR(`IDX_CAUSE);

   reset_seq_pkg::seq_regs_t s;
   reset_seq_pkg::seq_regs_t n;

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == ADDR_STATUS) || (a == ADDR_PC_LOW) || (a == ADDR_IRQ) ||
                   (a == ADDR_OPTION) || (a == ADDR_DIR_A) || (a == ADDR_DIR_B) ||
                   (a == ADDR_POWER_CONTROL_FLAGS) || (a == ADDR_CONFIG) || (a == ADDR_CAUSE);
   endfunction : addr_known

   function automatic logic [7:0] read_mux(input reset_seq_pkg::seq_regs_t r,
                                           input logic [11:0] a);
      read_mux = 8'h00;
      case (a)
         ADDR_STATUS: read_mux = r.status;
         ADDR_PC_LOW: read_mux = r.pc_low;
         ADDR_IRQ:    read_mux = r.irq_ctl;
         ADDR_OPTION: read_mux = r.option;
         ADDR_DIR_A:  read_mux = {3'h0, r.dir_a};
         ADDR_DIR_B:  read_mux = r.dir_b;
         ADDR_POWER_CONTROL_FLAGS:   read_mux = {6'h00, r.power_control_flags_por, 1'b0};
         ADDR_CONFIG: read_mux = {5'h00, r.cfg};
         ADDR_CAUSE:  read_mux = {r.state == reset_seq_pkg::ST_SLEEP, 4'h0, r.cause};
         default:     read_mux = 8'h00;
      endcase
   endfunction : read_mux

   always_comb begin
      logic supply_up;
      logic clear_fall;
      logic clk_in_rise;
      logic slow_rise;
      logic crystal;
      logic delay_on;
      logic wr_fire;
      logic do_reset_vals;
      logic begin_wake;
      n             = s;
      supply_up     = 1'b0;
      clear_fall    = 1'b0;
      clk_in_rise   = 1'b0;
      slow_rise     = 1'b0;
      crystal       = 1'b0;
      delay_on      = 1'b0;
      wr_fire       = 1'b0;
      do_reset_vals = 1'b0;
      begin_wake    = 1'b0;

      // three-stage synchroniser; a lane changes once stages two and three agree
      n.sync1 = {slow_osc_clk, clock_in_pin, master_clear_n, supply_rise};
      n.sync2 = s.sync1;
      n.sync3 = s.sync2;
      for (int i = 0; i < 4; i++) begin
         if (s.sync2[i] == s.sync3[i]) begin
            n.clean[i] = s.sync3[i];
         end
      end
      supply_up   = n.clean[`LANE_SUPPLY] & ~s.clean[`LANE_SUPPLY]; // R06
      clk_in_rise = n.clean[`LANE_CLOCK_IN] & ~s.clean[`LANE_CLOCK_IN];
      slow_rise   = n.clean[`LANE_SLOW_OSC] & ~s.clean[`LANE_SLOW_OSC];

      // width filter: a new level counts only after it has stood long enough
      if (s.clean[`LANE_MASTER_CLEAR] != s.clear_n) begin // R05
         n.filt_cnt = s.filt_cnt + 8'h01;
         if (s.filt_cnt == FILT_LAST) begin
            n.clear_n  = s.clean[`LANE_MASTER_CLEAR];
            n.filt_cnt = 8'h00;
         end
      end else begin
         n.filt_cnt = 8'h00;
      end
      clear_fall = s.clear_n & ~n.clear_n;

      crystal  = reset_seq_pkg::osc_mode_t'(s.cfg[1:0]) != reset_seq_pkg::OSC_RES_CAP; // R23
      delay_on = ~s.cfg[`CFG_DELAY_DIS_BIT]; // R09

      n.wd_clear = 1'b0;
      n.pc_load  = 1'b0;

      // divide-by-four clock output, frozen while the driver is off in sleep
      n.clock_out_oe = ~crystal;
      if (!crystal && s.osc_enable && clk_in_rise) begin // R01
         n.div_phase = ~s.div_phase;
         if (s.div_phase) begin
            n.clock_out = ~s.clock_out;
         end
      end
      if (crystal) begin
         n.clock_out = 1'b0;
         n.div_phase = 1'b0;
      end

      // axi write channel; address and data may arrive in either order
      if (s_axi_awvalid && s.awready) begin
         n.aw_got  = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         n.w_got   = 1'b1;
         n.w_data  = s_axi_wdata[7:0];
         n.w_lane0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         wr_fire  = s.w_lane0 && addr_known(s.aw_addr);
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = addr_known(s.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (wr_fire) begin
         case (s.aw_addr)
            ADDR_STATUS: begin
               n.status[7:5] = s.w_data[7:5];
               n.status[2:0] = s.w_data[2:0];
            end
            ADDR_PC_LOW: n.pc_low = s.w_data;
            ADDR_IRQ:    n.irq_ctl = s.w_data;
            ADDR_OPTION: n.option = s.w_data;
            ADDR_DIR_A:  n.dir_a = s.w_data[4:0];
            ADDR_DIR_B:  n.dir_b = s.w_data;
            ADDR_POWER_CONTROL_FLAGS:   n.power_control_flags_por = s.w_data[`POWER_CONTROL_FLAGS_POR_BIT]; // R15
            ADDR_CONFIG: n.cfg = s.w_data[2:0];
            default:     n.scratch = s.scratch;
         endcase
      end
      n.awready = ~n.aw_got & ~n.bvalid;
      n.wready  = ~n.w_got & ~n.bvalid;

      // axi read channel, answered one cycle after the address is taken
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         n.rvalid = 1'b1;
         n.rdata  = {24'h00_0000, read_mux(s, s_axi_araddr)};
         n.rresp  = addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      n.arready = ~n.rvalid;

      // start-up timers; hardware events below override software writes
      case (s.state)
         reset_seq_pkg::ST_POWER_UP: begin
            if (slow_rise) begin // R07
               n.delay_cnt = s.delay_cnt + 16'h0001;
               if (s.delay_cnt == DELAY_LAST) begin
                  n.state     = crystal ? reset_seq_pkg::ST_OSC_START
                                        : reset_seq_pkg::ST_RUN; // R12 R13
                  n.start_cnt = 11'h000;
               end
            end
         end
         reset_seq_pkg::ST_OSC_START: begin
            if (clk_in_rise) begin // R10
               n.start_cnt = s.start_cnt + 11'h001;
               if (s.start_cnt == START_LAST) begin
                  n.state = reset_seq_pkg::ST_RUN;
                  if (s.wake_start) begin
                     n.pc_load    = 1'b1; // R17
                     n.pc_value   = s.wake_pc;
                     n.wake_start = 1'b0;
                  end
               end
            end
         end
         reset_seq_pkg::ST_HOLD: n.state = reset_seq_pkg::ST_RUN;
         reset_seq_pkg::ST_RUN: begin
            if (s.vec_pending && instr_retired) begin
               n.pc_load     = 1'b1; // R17
               n.pc_value    = `IRQ_VECTOR;
               n.vec_pending = 1'b0;
            end
            if (sleep_exec && !s.core_reset) begin // R21
               n.status[`ST_POWERDOWN_BIT] = 1'b0;
               n.status[`ST_TIMEOUT_BIT]   = 1'b1;
               n.wd_clear   = 1'b1;
               n.osc_enable = 1'b0;
               n.state      = reset_seq_pkg::ST_SLEEP;
            end
         end
         reset_seq_pkg::ST_SLEEP: begin
            if (watchdog_timeout) begin // R02
               n.status[`ST_TIMEOUT_BIT]   = 1'b0; // R16 R18
               n.status[`ST_POWERDOWN_BIT] = 1'b0;
               n.cause    = reset_seq_pkg::CAUSE_WATCHDOG_WAKE;
               begin_wake = 1'b1;
            end else if (|irq_wake_req) begin // R02
               n.irq_ctl[2:0] = n.irq_ctl[2:0] | irq_wake_req; // R20
               n.status[`ST_TIMEOUT_BIT]   = 1'b1; // R16 R18
               n.status[`ST_POWERDOWN_BIT] = 1'b0;
               n.cause       = reset_seq_pkg::CAUSE_IRQ_WAKE;
               n.vec_pending = s.irq_ctl[`IRQ_GLOBAL_BIT]; // R17
               begin_wake    = 1'b1;
            end
         end
         default: n.state = reset_seq_pkg::ST_HOLD;
      endcase

      // wake keeps the other registers, loads pc low with pc+1 and resumes at pc+1
      if (begin_wake) begin // R04 R19
         n.osc_enable = 1'b1;
         n.wake_pc    = 13'(current_pc + 13'h0001);
         n.pc_low     = 8'(current_pc + 13'h0001);
         if (crystal) begin // R11
            n.state      = reset_seq_pkg::ST_OSC_START;
            n.start_cnt  = 11'h000;
            n.wake_start = 1'b1;
         end else begin
            n.state    = reset_seq_pkg::ST_RUN;
            n.pc_load  = 1'b1;
            n.pc_value = 13'(current_pc + 13'h0001);
         end
      end

      // watchdog reset while running; no start-up count follows
      if (watchdog_timeout && s.state == reset_seq_pkg::ST_RUN) begin // R02
         n.status[7:5]             = 3'h0; // R18
         n.status[`ST_TIMEOUT_BIT] = 1'b0; // R22 R16
         n.cause       = reset_seq_pkg::CAUSE_WATCHDOG;
         n.state       = reset_seq_pkg::ST_HOLD;
         do_reset_vals = 1'b1;
      end

      // master clear; power-up timers keep running from the power-on pulse
      if (clear_fall) begin // R02
         n.status[7:5] = 3'h0; // R18
         if (s.state == reset_seq_pkg::ST_SLEEP || s.wake_start) begin
            n.status[`ST_TIMEOUT_BIT]   = 1'b1; // R16
            n.status[`ST_POWERDOWN_BIT] = 1'b0;
            n.cause = reset_seq_pkg::CAUSE_CLEAR_SLEEP;
         end else begin
            n.cause = reset_seq_pkg::CAUSE_CLEAR_RUN;
         end
         if (s.state == reset_seq_pkg::ST_SLEEP || s.wake_start ||
             s.state == reset_seq_pkg::ST_RUN) begin // R14
            n.state      = reset_seq_pkg::ST_HOLD;
            n.wake_start = 1'b0;
         end
         n.osc_enable  = 1'b1;
         do_reset_vals = 1'b1;
      end

      // power-on restarts everything from the first stage
      if (supply_up) begin // R06 R25
         n.status      = {3'h0, 2'b11, s.status[2:0]}; // R18 R03
         n.power_control_flags_por    = 1'b0; // R15
         n.cause       = reset_seq_pkg::CAUSE_POWER_ON;
         n.delay_cnt   = 16'h0000;
         n.start_cnt   = 11'h000;
         n.wake_start  = 1'b0;
         n.osc_enable  = 1'b1;
         do_reset_vals = 1'b1;
         if (delay_on) begin // R09 R12
            n.state = reset_seq_pkg::ST_POWER_UP;
         end else if (crystal) begin // R11 R13
            n.state = reset_seq_pkg::ST_OSC_START;
         end else begin
            n.state = reset_seq_pkg::ST_HOLD;
         end
      end

      if (do_reset_vals) begin // R04 R19
         n.pc_low      = 8'h00;
         n.option      = `OPTION_RESET;
         n.dir_a       = `DIR_A_RESET;
         n.dir_b       = `DIR_B_RESET;
         n.irq_ctl     = {7'h00, s.irq_ctl[0]};
         n.vec_pending = 1'b0;
         n.pc_load     = 1'b1; // R17
         n.pc_value    = `RESET_VECTOR;
      end

      // release is a flop on this clock, so it leaves reset synchronously
      n.core_reset = ~n.clear_n || n.state == reset_seq_pkg::ST_POWER_UP || // R08 R24
                     n.state == reset_seq_pkg::ST_HOLD ||
                     (n.state == reset_seq_pkg::ST_OSC_START && !n.wake_start);
      n.core_stall = n.state == reset_seq_pkg::ST_SLEEP || n.wake_start;
   end

   // scratch stands for the registers no reset event touches
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s            <= '0;
         s.state      <= reset_seq_pkg::ST_HOLD;
         s.clear_n    <= 1'b1;
         s.clean      <= 4'h2;
         s.sync1      <= 4'h2;
         s.sync2      <= 4'h2;
         s.sync3      <= 4'h2;
         s.status     <= 8'h18;
         s.option     <= `OPTION_RESET;
         s.dir_a      <= `DIR_A_RESET;
         s.dir_b      <= `DIR_B_RESET;
         s.cfg        <= `CONFIG_RESET;
         s.cause      <= reset_seq_pkg::CAUSE_NONE;
         s.core_reset <= 1'b1;
         s.osc_enable <= 1'b1;
         s.awready    <= 1'b1;
         s.wready     <= 1'b1;
         s.arready    <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign s_axi_awready     = s.awready;
   assign s_axi_wready      = s.wready;
   assign s_axi_bresp       = s.bresp;
   assign s_axi_bvalid      = s.bvalid;
   assign s_axi_arready     = s.arready;
   assign s_axi_rdata       = s.rdata;
   assign s_axi_rresp       = s.rresp;
   assign s_axi_rvalid      = s.rvalid;
   assign core_reset        = s.core_reset;
   assign core_stall        = s.core_stall;
   assign osc_driver_enable = s.osc_enable;
   assign watchdog_clear    = s.wd_clear;
   assign pc_load           = s.pc_load;
   assign pc_value          = s.pc_value;
   assign clock_out_pin     = s.clock_out;
   assign clock_out_oe      = s.clock_out_oe;
   assign reset_cause       = s.cause;

endmodule : reset_timeout_sequencer

// >>> tb/reset_seq_props.sv
`timescale 1ns/100ps
module reset_seq_props (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // observed
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        sleep_exec,
   input wire logic        watchdog_timeout,
   input wire logic        core_reset,
   input wire logic        core_stall,
   input wire logic        osc_driver_enable,
   input wire logic        watchdog_clear,
   input wire logic        pc_load,
   input wire logic [12:0] pc_value,
   input wire logic        clock_out_pin,
   input wire logic        clock_out_oe,
   input wire logic [2:0]  reset_cause
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // sleep entry and watchdog reset are only checked while the core runs
   sequence s_run;
      !core_reset && !core_stall;
   endsequence
   a_sleep_entry: assert property (s_run ##0 sleep_exec |=> watchdog_clear && core_stall)
      else $error("sleep entry not seen");
   a_osc_stop: assert property (!osc_driver_enable |-> core_stall)
      else $error("oscillator stopped outside sleep");
   a_wdclr_pulse: assert property (watchdog_clear |=> !watchdog_clear)
      else $error("watchdog clear longer than one cycle");
   a_wd_reset: assert property (s_run ##0 watchdog_timeout |=> core_reset && reset_cause == 3'h4)
      else $error("watchdog reset not taken");
   a_pc_pulse: assert property (pc_load |=> !pc_load)
      else $error("pc load longer than one cycle");
   a_reset_vector: assert property (pc_load && core_reset |-> pc_value == 13'h0000)
      else $error("reset load is not the reset vector");
   a_clkout_idle: assert property (!clock_out_oe |-> !clock_out_pin)
      else $error("clock out moves while not driven");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule : reset_seq_props

bind reset_timeout_sequencer reset_seq_props u_props (.*);

// >>> tb/tb_reset_timeout_sequencer.sv
`timescale 1ns/100ps
module tb_reset_timeout_sequencer;
   logic clock = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, supply_rise = 0, master_clear_n = 1;
   logic clock_in_pin = 0, slow_osc_clk = 0, watchdog_timeout = 0, sleep_exec = 0;
   logic instr_retired = 0;
   logic [2:0] irq_wake_req = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [12:0] current_pc = 13'h0123, pc_value;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic core_reset, core_stall, osc_driver_enable, watchdog_clear, pc_load;
   logic clock_out_pin, clock_out_oe;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] reset_cause;
   int n_errors = 0, total_checks = 0, n;
   realtime t0;
   localparam logic [11:0] A_ST = 12'h00c, A_IRQ = 12'h02c, A_OPT = 12'h204;
   localparam logic [11:0] A_POWER_CONTROL_FLAGS = 12'h238, A_CFG = 12'h240;
   localparam logic [31:0] SM = 32'h0000_00f8;
   // short timer counts keep the power-up path inside the run length
   reset_timeout_sequencer #(.POWER_UP_TICKS(4), .OSC_START_CYCLES(4)) u_dut (.*);
   always #4 clock = ~clock;
   always #20 clock_in_pin = ~clock_in_pin;
   always #40 slow_osc_clk = ~slow_osc_clk;
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic wait_pc(input logic [12:0] e);
      for (int i = 0; i < 60 && pc_load !== 1'b1; i++) @(posedge clock);
      total_checks++;
      if (pc_value !== e || pc_load !== 1'b1) begin
         n_errors++;
         $display("ERROR pc_value exp %h got %h", e, pc_value);
      end
   endtask : wait_pc
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask : cyc
   task automatic wait_rst(input logic v);
      n = 0;
      while (core_reset !== v && n < 5000) begin
         @(posedge clock);
         n++;
      end
      if (core_reset !== v) n_errors++;
   endtask : wait_rst
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      forever begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      forever begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd
   task automatic slp;
      sleep_exec <= 1;
      @(posedge clock);
      sleep_exec <= 0;
      cyc(3);
   endtask : slp
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200_000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      cyc(6);
      rst_n <= 1;
      cyc(2);
      wr(A_OPT, 8'h00);
      supply_rise <= 1;
      wait_rst(1);
      wait_rst(0);
      chk("por_len", 1, n >= 40);
      rd(A_ST); chk("status", 8'h18, d & SM);
      rd(A_POWER_CONTROL_FLAGS); chk("power_control_flags", 0, d);
      rd(A_OPT); chk("option", 8'hff, d);
      chk("cause", 1, reset_cause);
      wr(A_POWER_CONTROL_FLAGS, 8'h02);
      wr(A_OPT, 8'h00);
      watchdog_timeout <= 1;
      @(posedge clock);
      watchdog_timeout <= 0;
      wait_rst(1);
      wait_rst(0);
      rd(A_ST); chk("status", 8'h08, d & SM);
      rd(A_POWER_CONTROL_FLAGS); chk("power_control_flags", 8'h02, d);
      rd(A_OPT); chk("option", 8'hff, d);
      chk("cause", 4, reset_cause);
      master_clear_n <= 0;
      cyc(100);
      master_clear_n <= 1;
      cyc(300);
      chk("cause", 4, reset_cause);
      master_clear_n <= 0;
      cyc(300);
      chk("core_reset", 1, core_reset);
      master_clear_n <= 1;
      wait_rst(0);
      chk("cause", 2, reset_cause);
      rd(A_ST); chk("status", 8'h08, d & SM);
      // resistor-capacitor mode with the power-up delay switched off
      wr(A_CFG, 8'h07);
      supply_rise <= 0;
      cyc(20);
      chk("cause", 2, reset_cause);
      supply_rise <= 1;
      wait_rst(1);
      wait_rst(0);
      chk("rc_len", 1, n <= 8);
      chk("clk_oe", 1, clock_out_oe);
      @(posedge clock_out_pin);
      t0 = $realtime;
      @(posedge clock_out_pin);
      chk("clk_div", 1, $realtime - t0 > 150 && $realtime - t0 < 170);
      wr(A_IRQ, 8'h80);
      wr(A_OPT, 8'h55);
      slp();
      chk("osc_en", 0, osc_driver_enable);
      rd(A_ST); chk("status", 8'h10, d & SM);
      irq_wake_req <= 3'h2;
      @(posedge clock);
      irq_wake_req <= 0;
      wait_pc(13'h0124);
      instr_retired <= 1;
      @(posedge clock);
      instr_retired <= 0;
      wait_pc(13'h0004);
      rd(A_IRQ); chk("irq_ctl", 8'h82, d & 8'h82);
      rd(A_OPT); chk("option", 8'h55, d);
      rd(A_ST); chk("status", 8'h10, d & SM);
      chk("cause", 6, reset_cause);
      slp();
      watchdog_timeout <= 1;
      @(posedge clock);
      watchdog_timeout <= 0;
      wait_pc(13'h0124);
      rd(A_ST); chk("status", 8'h00, d & SM);
      chk("cause", 5, reset_cause);
      slp();
      master_clear_n <= 0;
      cyc(300);
      master_clear_n <= 1;
      wait_rst(0);
      chk("cause", 3, reset_cause);
      rd(A_ST); chk("status", 8'h10, d & SM);
      rd(A_OPT); chk("option", 8'hff, d);
      wr(A_CFG, 8'h06);
      slp();
      watchdog_timeout <= 1;
      @(posedge clock);
      watchdog_timeout <= 0;
      cyc(8);
      chk("stall", 1, core_stall);
      wait_pc(13'h0124);
      rd(12'hffc);
      chk("resp", 2, r);
      wr(12'hffc, 8'h00);
      chk("bresp", 2, r);
      tally_and_finish();
   end
endmodule : tb_reset_timeout_sequencer
